// ==== fault_params.svh ====
// constants for the input fault response block
`ifndef FAULT_PARAMS_SVH
`define FAULT_PARAMS_SVH
`define CMD_UV_FAULT_LIMIT      8'h59
`define CMD_UV_FAULT_ACTION     8'h5a
`define CMD_OC_THRESHOLD        8'h5b
`define UV_ACTION_RESET         8'h84
`define OC_THRESHOLD_RESET      16'h1388
`define UV_LIMIT_RESET          16'h0000
`define ACT_SEL_MSB             7
`define ACT_SEL_LSB             6
`define RETRY_MSB               5
`define RETRY_LSB               3
`define DELAY_MSB               2
`define DELAY_LSB               0
`define HYST_SHIFT              4
`define DELAY_STEP_MS           25
`define DELAY_MAX_MS            175
`define CLK_HZ                  100000000
`define DELAY_STEP_CYCLES       ((`DELAY_STEP_MS * `CLK_HZ) / 1000)
`endif

// ==== fault_pkg.sv ====
// types for the input fault response block
package fault_pkg;
    typedef enum logic [1:0]
    {
        ACT_CONTINUE = 2'h0,
        ACT_BAD1     = 2'h1,
        ACT_SHUTDOWN = 2'h2,
        ACT_BAD3     = 2'h3
    } fault_action_select_e;

    typedef enum logic [2:0]
    {
        RETRY_NONE    = 3'h0,
        RETRY_FOREVER = 3'h7
    } retry_code_e;

    typedef struct packed
    {
        fault_action_select_e fault_action_select;
        logic [2:0]           retry;
        logic [2:0]           delay;
    } uv_action_s;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [15:0] wdata;
        logic [1:0]  page;
    } reg_req_s;

    typedef enum logic [3:0]
    {
        ST_RUN     = 4'b0001,
        ST_FAULTED = 4'b0010,
        ST_WAIT    = 4'b0100,
        ST_LATCHED = 4'b1000
    } fault_state_e;
endpackage

// ==== retry_timer.sv ====
// retry delay counter
`timescale 1ns/1ps
`include "fault_params.svh"
module retry_timer
    import fault_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `DELAY_STEP_CYCLES
)
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       start_i,
    input  wire logic [2:0] code_i,
    output logic            done_o
);
    logic [31:0] cycles_left;
    logic        running;

    // 111 is 7 steps: 175 ms equals 7 x 25 ms
    function automatic logic [31:0] delay_cycles(input logic [2:0] code);
        delay_cycles = 32'(code) * 32'(STEP_CYCLES);
    endfunction

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cycles_left <= 32'h0;
            running     <= 1'b0;
            done_o      <= 1'b0;
        end
        else if (start_i)
        begin
            cycles_left <= delay_cycles(code_i);
            running     <= 1'b1;
            done_o      <= 1'b0;
        end
        else if (running)
        begin
            // done stays up until the next start, so a late clear still retries
            done_o <= (cycles_left <= 32'h1);
            running <= (cycles_left > 32'h1);
            if (cycles_left != 32'h0)
                cycles_left <= cycles_left - 32'h1;
        end
    end
endmodule // retry_timer

// ==== input_fault_response_logic.sv ====
// input undervoltage response and input overcurrent threshold
`timescale 1ns/1ps
`include "fault_params.svh"
module input_fault_response_logic
    import fault_pkg::*;
#(
    parameter int unsigned PAGES       = 2,
    parameter int unsigned STEP_CYCLES = `DELAY_STEP_CYCLES
)
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire reg_req_s    req_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output logic             cmd_err_o,
    input  wire logic [15:0] vin_reading_i,
    input  wire logic [15:0] iin_reading_i,
    input  wire logic        enable_cmd_i,
    input  wire logic        bias_good_i,
    input  wire logic        other_fault_i,
    input  wire logic        restart_i,
    input  wire logic        clear_faults_i,
    output logic             output_enable_o,
    output logic             uv_fault_flag_o,
    output logic             oc_fault_flag_o,
    output logic             alert_line_n_o,
    output logic             alert_line_n_oe_o
);
    localparam int unsigned PW = (PAGES > 1) ? $clog2(PAGES) : 1;

    logic [7:0]  uv_action [PAGES];
    logic [15:0] oc_limit  [PAGES];
    logic [15:0] uv_limit  [PAGES];
    logic [PW-1:0] pg;
    logic [1:0]  sync_en;
    logic [1:0]  sync_bias;
    logic [1:0]  sync_oth;
    logic        en_s;
    logic        bias_s;
    logic        oth_s;
    logic        uv_active;
    logic        uv_now;
    logic        uv_clear_ok;
    logic        oc_now;
    logic        timer_start;
    logic        timer_done;
    logic        stop_retry;
    uv_action_s  act;
    fault_state_e state;
    fault_state_e next_state;

    // page select is narrowed to the stored copies
    assign pg = req_i.page[PW-1:0];
    assign act = uv_action_s'(uv_action[0]);

    // hysteresis: threshold plus threshold/16, signed
    function automatic logic signed [17:0] clear_level(input logic [15:0] lim);
        clear_level = 18'($signed(lim)) + 18'($signed(lim) >>> `HYST_SHIFT);
    endfunction

    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = (c == `CMD_UV_FAULT_ACTION) || (c == `CMD_OC_THRESHOLD) || (c == `CMD_UV_FAULT_LIMIT);
    endfunction

    // page number must name a stored copy
    function automatic logic page_ok(input logic [1:0] p);
        page_ok = (32'(p) < PAGES);
    endfunction

    // codes 01 and 11 are unsupported and behave like continue
    function automatic logic shuts_down(input uv_action_s a);
        shuts_down = (a.fault_action_select == ACT_SHUTDOWN);
    endfunction

    // codes 001 to 110 are unsupported and latch off like 000
    function automatic logic retries(input uv_action_s a);
        retries = (a.retry == RETRY_FOREVER);
    endfunction

    // register writes, one copy per page; a refused page or command stores nothing
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < PAGES; i++)
                uv_action[i] <= `UV_ACTION_RESET;
        end
        else if (req_i.wr && page_ok(req_i.page) && (req_i.cmd == `CMD_UV_FAULT_ACTION))
        begin
            uv_action[pg] <= req_i.wdata[7:0];
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < PAGES; i++)
                oc_limit[i] <= `OC_THRESHOLD_RESET;
        end
        else if (req_i.wr && page_ok(req_i.page) && (req_i.cmd == `CMD_OC_THRESHOLD))
        begin
            oc_limit[pg] <= req_i.wdata;
        end
    end

    // limit kept here so the undervoltage compare has a programmable threshold
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < PAGES; i++)
                uv_limit[i] <= `UV_LIMIT_RESET;
        end
        else if (req_i.wr && page_ok(req_i.page) && (req_i.cmd == `CMD_UV_FAULT_LIMIT))
        begin
            uv_limit[pg] <= req_i.wdata;
        end
    end

    // read strobe answered one cycle later
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            rvalid_o <= 1'b0;
        else
            rvalid_o <= req_i.rd;
    end

    // unknown command or missing page is refused for reads and writes alike
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            cmd_err_o <= 1'b0;
        else
            cmd_err_o <= (req_i.rd || req_i.wr) && (!known_cmd(req_i.cmd) || !page_ok(req_i.page));
    end

    // read data holds until the next read
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_o <= 16'h0;
        else if (req_i.rd && page_ok(req_i.page))
        begin
            case (req_i.cmd)
                `CMD_UV_FAULT_ACTION: rdata_o <= {8'h0, uv_action[pg]};
                `CMD_OC_THRESHOLD:    rdata_o <= oc_limit[pg];
                `CMD_UV_FAULT_LIMIT:  rdata_o <= uv_limit[pg];
                default:              rdata_o <= 16'h0;
            endcase
        end
        else if (req_i.rd)
        begin
            rdata_o <= 16'h0;
        end
    end

    // control pins come from outside the clock domain; two flops against metastability
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            sync_en <= 2'h0;
        else
            sync_en <= {sync_en[0], enable_cmd_i};
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            sync_bias <= 2'h0;
        else
            sync_bias <= {sync_bias[0], bias_good_i};
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            sync_oth <= 2'h0;
        else
            sync_oth <= {sync_oth[0], other_fault_i};
    end
    assign en_s   = sync_en[1];
    assign bias_s = sync_bias[1];
    assign oth_s  = sync_oth[1];

    // page 0 drives the shared input stage
    assign uv_now      = $signed(vin_reading_i) < $signed(uv_limit[0]);
    assign uv_clear_ok = 18'($signed(vin_reading_i)) > clear_level(uv_limit[0]);
    assign oc_now      = $signed(iin_reading_i) > $signed(oc_limit[0]);

    // fault stays active until voltage clears the hysteresis band
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            uv_active <= 1'b0;
        else if (uv_now)
            uv_active <= 1'b1;
        else if (uv_clear_ok)
            uv_active <= 1'b0;
    end

    // sticky flags; a new fault wins over a clear
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            uv_fault_flag_o <= 1'b0;
            oc_fault_flag_o <= 1'b0;
        end
        else
        begin
            if (uv_now)
                uv_fault_flag_o <= 1'b1;
            else if (clear_faults_i)
                uv_fault_flag_o <= 1'b0;
            if (oc_now)
                oc_fault_flag_o <= 1'b1;
            else if (clear_faults_i)
                oc_fault_flag_o <= 1'b0;
        end
    end

    // open drain: drive low only while a flag stands
    assign alert_line_n_o    = 1'b0;
    assign alert_line_n_oe_o = uv_fault_flag_o || oc_fault_flag_o;

    assign stop_retry = !en_s || !bias_s || oth_s;

    always_comb
    begin
        next_state  = state;
        timer_start = 1'b0;
        case (state)
            ST_RUN:
            begin
                // unsupported action codes are treated as continue
                if (uv_now && en_s && shuts_down(act))
                    next_state = ST_FAULTED;
            end
            ST_FAULTED:
            begin
                if (retries(act) && !stop_retry)
                begin
                    next_state  = ST_WAIT;
                    timer_start = 1'b1;
                end
                else
                    next_state = ST_LATCHED;
            end
            ST_WAIT:
            begin
                if (stop_retry)
                    next_state = ST_LATCHED;
                else if (timer_done && !uv_active)
                    next_state = ST_RUN;
            end
            ST_LATCHED:
            begin
                // unsupported retry codes latch off as well
                if (restart_i)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            output_enable_o <= 1'b0;
        else
            output_enable_o <= (next_state == ST_RUN) && en_s && bias_s;
    end

    // zero delay code restarts almost at once, which the host should avoid
    retry_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .start_i (timer_start),
        .code_i  (act.delay),
        .done_o  (timer_done)
    );
endmodule // input_fault_response_logic

// ==== input_fault_response_logic_sva.sv ====
// port checker for the input fault response block
`timescale 1ns/1ps
module input_fault_response_logic_sva
    import fault_pkg::*;
#(
    parameter int unsigned PAGES = 2
)
(
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire reg_req_s    req_i,
    input wire logic [15:0] rdata_o,
    input wire logic        rvalid_o,
    input wire logic        cmd_err_o,
    input wire logic [15:0] vin_reading_i,
    input wire logic        enable_cmd_i,
    input wire logic        bias_good_i,
    input wire logic        clear_faults_i,
    input wire logic        output_enable_o,
    input wire logic        uv_fault_flag_o,
    input wire logic        oc_fault_flag_o,
    input wire logic        alert_line_n_o,
    input wire logic        alert_line_n_oe_o
);
    logic [15:0] uv_limit;
    // shadow of the page 0 limit, the only copy that arms faults
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            uv_limit <= 16'h0000;
        else if (req_i.wr && req_i.cmd == 8'h59 && req_i.page == 2'h0)
            uv_limit <= req_i.wdata;
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    AST_READ_ANSWER: assert property (req_i.rd && req_i.cmd == 8'h5b && req_i.page < PAGES |=> rvalid_o)
        else $error("register read not answered");
    AST_BAD_PAGE: assert property ((req_i.rd || req_i.wr) && req_i.page >= PAGES |=> cmd_err_o)
        else $error("bad page not refused");
    AST_VALID_CAUSE: assert property (rvalid_o |-> $past(req_i.rd))
        else $error("read valid without read");
    AST_RDATA_HOLD: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without read");
    AST_OPEN_DRAIN: assert property (!alert_line_n_o && alert_line_n_oe_o == (uv_fault_flag_o || oc_fault_flag_o))
        else $error("alert line does not follow flags");
    AST_UV_CAUSE: assert property ($rose(uv_fault_flag_o) |-> $signed($past(vin_reading_i)) < $signed($past(uv_limit)))
        else $error("uv flag without low input");
    AST_UV_STICKY: assert property (uv_fault_flag_o && !clear_faults_i |=> uv_fault_flag_o)
        else $error("uv flag dropped without clear");
    AST_BIAS_LOST: assert property (!bias_good_i [*4] |-> !output_enable_o)
        else $error("output on without bias");
    AST_CMD_OFF: assert property (!enable_cmd_i [*4] |-> !output_enable_o)
        else $error("output on while commanded off");
endmodule // input_fault_response_logic_sva
bind input_fault_response_logic input_fault_response_logic_sva #(.PAGES(PAGES)) sva_chk
(
    .mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .cmd_err_o(cmd_err_o), .vin_reading_i(vin_reading_i), .enable_cmd_i(enable_cmd_i),
    .bias_good_i(bias_good_i), .clear_faults_i(clear_faults_i), .output_enable_o(output_enable_o),
    .uv_fault_flag_o(uv_fault_flag_o), .oc_fault_flag_o(oc_fault_flag_o),
    .alert_line_n_o(alert_line_n_o), .alert_line_n_oe_o(alert_line_n_oe_o)
);

// ==== pmbus_host.sv ====
// command host model for the fault block's register port
`timescale 1ns/1ps
module pmbus_host
    import fault_pkg::*;
(
    input  wire logic        mclk_i,
    output reg_req_s         req_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    input  wire logic        cmd_err_i
);
    initial req_o = '0;
    // one-cycle request, answer taken after the next edge
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [1:0] page, input logic [15:0] wdata,
                        output logic [15:0] rd, output logic ok, output logic err);
        logic [15:0] w;
        w = wdata;
        // zero retry delay is never programmed
        if (wr && cmd == 8'h5a && w[2:0] == 3'h0)
            w[2:0] = 3'h1;
        @(posedge mclk_i);
        req_o <= '{wr: wr, rd: !wr, cmd: cmd, wdata: w, page: page};
        @(posedge mclk_i);
        req_o <= '0;
        @(negedge mclk_i);
        rd = rdata_i;
        ok = rvalid_i;
        err = cmd_err_i;
    endtask
endmodule // pmbus_host

// ==== input_fault_response_logic_test.sv ====
// self-checking bench for the input fault response block
`timescale 1ns/1ps
module input_fault_response_logic_test;
    import fault_pkg::*;
    localparam int unsigned STEP = 10;
    logic        mclk_i;
    logic        reset_i;
    reg_req_s    req;
    logic [15:0] rdata, vin, iin;
    logic        rvalid, cmd_err, pwr, uv_flag, oc_flag, alert_n, alert_oe;
    logic        en, bias, other, restart, clr;
    int          n_fail = 0;
    int          comparisons = 0;
    input_fault_response_logic #(.PAGES(2), .STEP_CYCLES(STEP)) uut
    (
        .mclk_i(mclk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .cmd_err_o(cmd_err), .vin_reading_i(vin), .iin_reading_i(iin), .enable_cmd_i(en),
        .bias_good_i(bias), .other_fault_i(other), .restart_i(restart), .clear_faults_i(clr),
        .output_enable_o(pwr), .uv_fault_flag_o(uv_flag), .oc_fault_flag_o(oc_flag),
        .alert_line_n_o(alert_n), .alert_line_n_oe_o(alert_oe)
    );
    pmbus_host host
    (
        .mclk_i(mclk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_err_i(cmd_err)
    );
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h got %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [1:0] pg, input logic [15:0] exp, input logic bad);
        logic [15:0] d;
        logic        v, e;
        host.xfer(1'b0, cmd, pg, 16'h0, d, v, e);
        chk("read valid", 16'h1, {15'h0, v});
        chk("read data", exp, d);
        chk("refusal", {15'h0, bad}, {15'h0, e});
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [1:0] pg, input logic [15:0] val);
        logic [15:0] d;
        logic        v, e;
        host.xfer(1'b1, cmd, pg, val, d, v, e);
        chk("write refusal", 16'h0, {15'h0, e});
    endtask
    // bounded wait on the power enable, returns cycles spent
    task automatic wait_pwr(input logic lvl, input int lim, output int n);
        n = 0;
        while (pwr !== lvl && n < lim)
        begin
            @(negedge mclk_i);
            n++;
        end
        chk("power enable wait", {15'h0, lvl}, {15'h0, pwr});
        if (pwr !== lvl)
            wrap_up();
    endtask
    task automatic pulse_clear();
        @(posedge mclk_i) clr <= 1'b1;
        @(posedge mclk_i) clr <= 1'b0;
    endtask
    task automatic t_regs();
        rd(8'h5a, 2'h0, 16'h0084, 1'b0);
        rd(8'h5b, 2'h1, 16'h1388, 1'b0);
        wr(8'h5b, 2'h1, 16'h8000);
        rd(8'h5b, 2'h1, 16'h8000, 1'b0);
        rd(8'h5b, 2'h0, 16'h1388, 1'b0);
        wr(8'h5a, 2'h1, 16'hffc7);
        rd(8'h5a, 2'h1, 16'h00c7, 1'b0);
        rd(8'h5a, 2'h2, 16'h0000, 1'b1);
        $display("test registers done");
    endtask
    task automatic t_latch();
        int n;
        wait_pwr(1'b1, 20, n);
        wr(8'h59, 2'h0, 16'd1000);
        @(posedge mclk_i) vin <= 16'd900;
        wait_pwr(1'b0, 5, n);
        chk("uv flag", 16'h1, {15'h0, uv_flag});
        chk("alert drive", 16'h1, {15'h0, alert_oe});
        chk("alert level", 16'h0, {15'h0, alert_n});
        @(posedge mclk_i) vin <= 16'd2000;
        repeat (50) @(posedge mclk_i);
        chk("latched off", 16'h0, {15'h0, pwr});
        restart <= 1'b1;
        @(posedge mclk_i) restart <= 1'b0;
        wait_pwr(1'b1, 10, n);
        pulse_clear();
        @(negedge mclk_i);
        chk("uv flag cleared", 16'h0, {15'h0, uv_flag});
        $display("test latch off done");
    endtask
    task automatic t_cont();
        wr(8'h5a, 2'h0, 16'h0004);
        @(posedge mclk_i) vin <= 16'd900;
        repeat (10) @(posedge mclk_i);
        chk("continue on fault", 16'h1, {15'h0, pwr});
        chk("uv flag on continue", 16'h1, {15'h0, uv_flag});
        @(posedge mclk_i) vin <= 16'd2000;
        pulse_clear();
        $display("test continue done");
    endtask
    // signed compare: 101 is above a limit of -100
    task automatic t_oc();
        wr(8'h5b, 2'h0, 16'h0064);
        @(posedge mclk_i) iin <= 16'h0064;
        repeat (5) @(posedge mclk_i);
        chk("oc at limit", 16'h0, {15'h0, oc_flag});
        iin <= 16'h0065;
        repeat (5) @(posedge mclk_i);
        chk("oc above limit", 16'h1, {15'h0, oc_flag});
        wr(8'h5b, 2'h0, 16'hff9c);
        pulse_clear();
        repeat (5) @(posedge mclk_i);
        chk("oc negative limit", 16'h1, {15'h0, oc_flag});
        wr(8'h5b, 2'h0, 16'h1388);
        pulse_clear();
        $display("test overcurrent done");
    endtask
    // command pin and bias both gate the output
    task automatic t_pins();
        int n;
        @(posedge mclk_i) en <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk("off by command pin", 16'h0, {15'h0, pwr});
        en <= 1'b1;
        wait_pwr(1'b1, 6, n);
        @(posedge mclk_i) bias <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk("off without bias", 16'h0, {15'h0, pwr});
        bias <= 1'b1;
        wait_pwr(1'b1, 6, n);
        $display("test pins done");
    endtask
    task automatic t_retry();
        logic [2:0] codes[3] = '{3'h1, 3'h6, 3'h7};
        int         n;
        foreach (codes[i])
        begin
            wr(8'h5a, 2'h0, {8'h0, 5'b10111, codes[i]});
            @(posedge mclk_i) vin <= 16'd900;
            wait_pwr(1'b0, 5, n);
            @(posedge mclk_i) vin <= 16'd1062;
            repeat (90) @(posedge mclk_i);
            chk("held inside hysteresis", 16'h0, {15'h0, pwr});
            vin <= 16'd1063;
            wait_pwr(1'b1, 10, n);
            @(posedge mclk_i) vin <= 16'd900;
            wait_pwr(1'b0, 5, n);
            @(posedge mclk_i) vin <= 16'd2000;
            wait_pwr(1'b1, 100, n);
            chk("retry delay", 16'h1, {15'h0, n >= codes[i] * STEP - 2 && n <= codes[i] * STEP + 4});
        end
        @(posedge mclk_i) vin <= 16'd900;
        wait_pwr(1'b0, 5, n);
        @(posedge mclk_i) vin <= 16'd2000;
        other <= 1'b1;
        repeat (100) @(posedge mclk_i);
        chk("retry stopped", 16'h0, {15'h0, pwr});
        $display("test retry done");
    endtask
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial
    begin
        reset_i = 1'b1;
        vin = 16'd2000;
        iin = 16'h0000;
        en = 1'b1;
        bias = 1'b1;
        other = 1'b0;
        restart = 1'b0;
        clr = 1'b0;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_regs();
        t_latch();
        t_cont();
        t_oc();
        t_pins();
        t_retry();
        wrap_up();
    end
endmodule // input_fault_response_logic_test
